//--- cwg_pkg.sv
// package of constants and types for the core wakeup reset debug gate
// ==========================================================================
// Notes on behaviour
// (RULE_01) emulation debug state holds while any debug session state remains set
// (RULE_02) warm pin reset during emulation debug state leaves affected cores stalled
// (RULE_03) power-on or full-chip reset wakes and starts every core regardless
// (RULE_04) with no emulator attached, warm pin reset wakes all cores normally
// (RULE_05) debugger must free-run, then detach every core, then apply warm reset
// (RULE_06) free-run then detach of every core clears all debug state
// (RULE_07) skipping free-run or detach leaves cores unable to start after warm reset
// (RULE_08) one debug state flag per core, set on halt or attach, cleared when freed
// ==========================================================================
package cwg_pkg;
    localparam int unsigned CWG_NUM_CORES_DEF = 4;
    localparam int unsigned CWG_WAKE_CYCLES   = 4;
    localparam logic [2:0]  CWG_WAKE_CNT_RST  = 3'h0;

    typedef enum logic [1:0] {
        CWG_ST_RUN   = 2'b00,
        CWG_ST_WAKE  = 2'b01,
        CWG_ST_RESET = 2'b10
    } cwg_state_e;
endpackage

//--- cwg_if.sv
// interface carrying per-core debug requests to the tracker
interface cwg_dbg_if #(parameter int unsigned N = 4);
    logic [N-1:0] halt;
    logic [N-1:0] attach;
    logic [N-1:0] free_run;
    logic [N-1:0] detach;
    logic [N-1:0] dbg_state;
    modport src (output halt, output attach, output free_run, output detach, input dbg_state);
    modport trk (input halt, input attach, input free_run, input detach, output dbg_state);
endinterface

//--- cwg_dbg_track.sv
// per-core debug state tracker
module cwg_dbg_track
    import cwg_pkg::*;
#(
    parameter int unsigned N = CWG_NUM_CORES_DEF
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic hard_rst_i,
    cwg_dbg_if.trk    dbg
);
    typedef struct packed {
        logic [N-1:0] halted;
        logic [N-1:0] attached;
    } cwg_trk_s;

    cwg_trk_s st_ff;
    cwg_trk_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // set wins over clear for the same core in the same cycle
        nxt_st.halted   = (st_ff.halted & ~dbg.free_run) | dbg.halt;       // [RULE_08]
        nxt_st.attached = (st_ff.attached & ~dbg.detach) | dbg.attach;     // [RULE_08]
        if (hard_rst_i) begin
            nxt_st = '0;                                                   // [RULE_03]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // a core stays in debug until free-run clears its halt flag and detach clears its attach flag
    assign dbg.dbg_state = st_ff.halted | st_ff.attached;                 // [RULE_06] [RULE_07]
endmodule

//--- cwg_top.sv
// core wakeup gate: resets and per-core debug state decide which cores start
module cwg_top
    import cwg_pkg::*;
#(
    parameter int unsigned N = CWG_NUM_CORES_DEF
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         por_n_i,
    input  wire logic         full_chip_reset_pin_n_i,
    input  wire logic         warm_reset_pin_n_i,
    input  wire logic [N-1:0] dbg_halt_i,
    input  wire logic [N-1:0] dbg_attach_i,
    input  wire logic [N-1:0] dbg_free_run_i,
    input  wire logic [N-1:0] dbg_detach_i,
    output logic [N-1:0]      core_run_o,
    output logic [N-1:0]      core_stuck_o,
    output logic [N-1:0]      core_dbg_o,
    output logic              emu_dbg_o
);
    // ======================================================================
    // pin synchronisers
    // ======================================================================
    typedef struct packed {
        logic [2:0]   s1;
        logic [2:0]   s2;
        logic [2:0]   prev;
        logic [N-1:0] h1;
        logic [N-1:0] h2;
        logic [N-1:0] a1;
        logic [N-1:0] a2;
        logic [N-1:0] f1;
        logic [N-1:0] f2;
        logic [N-1:0] d1;
        logic [N-1:0] d2;
        cwg_state_e   state;
        logic [2:0]   cnt;
        logic [N-1:0] run;
        logic [N-1:0] stuck;
        logic [N-1:0] dbg_at_reset;
        logic         emu;
    } cwg_top_s;

    cwg_top_s st_ff;
    cwg_top_s nxt_st;
    logic     hard_rst;
    logic     warm_rst;
    logic     any_rst;

    cwg_dbg_if #(.N(N)) dbg_bus ();

    // reset pins are active low; s2 order: {por, full, warm}
    assign hard_rst = ~st_ff.s2[2] | ~st_ff.s2[1];
    assign warm_rst = ~st_ff.s2[0];
    assign any_rst  = hard_rst | warm_rst;

    assign dbg_bus.halt     = st_ff.h2;
    assign dbg_bus.attach   = st_ff.a2;
    assign dbg_bus.free_run = st_ff.f2;
    assign dbg_bus.detach   = st_ff.d2;

    cwg_dbg_track #(.N(N)) u_trk (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .hard_rst_i (hard_rst),
        .dbg        (dbg_bus)
    );

    // ======================================================================
    // wake sequencer
    // ======================================================================
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.s1   = {por_n_i, full_chip_reset_pin_n_i, warm_reset_pin_n_i};
        nxt_st.s2   = st_ff.s1;
        nxt_st.prev = st_ff.s2;
        nxt_st.h1   = dbg_halt_i;
        nxt_st.h2   = st_ff.h1;
        nxt_st.a1   = dbg_attach_i;
        nxt_st.a2   = st_ff.a1;
        nxt_st.f1   = dbg_free_run_i;
        nxt_st.f2   = st_ff.f1;
        nxt_st.d1   = dbg_detach_i;
        nxt_st.d2   = st_ff.d1;
        nxt_st.emu  = |dbg_bus.dbg_state;                                  // [RULE_01]
        case (st_ff.state)
            CWG_ST_RUN: begin
                if (any_rst) begin
                    nxt_st.state = CWG_ST_RESET;
                end
            end
            CWG_ST_RESET: begin
                nxt_st.run = '0;
                nxt_st.cnt = CWG_WAKE_CNT_RST;
                if (hard_rst) begin
                    nxt_st.stuck        = '0;                              // [RULE_03]
                    nxt_st.dbg_at_reset = '0;
                end else if (warm_rst) begin
                    // a core still in debug while the warm pin is low is latched as lost
                    nxt_st.dbg_at_reset = st_ff.dbg_at_reset
                                        | dbg_bus.dbg_state;               // [RULE_02] [RULE_05]
                end
                if (!any_rst) begin
                    nxt_st.state = CWG_ST_WAKE;
                end
            end
            CWG_ST_WAKE: begin
                if (any_rst) begin
                    nxt_st.state = CWG_ST_RESET;
                end else if (st_ff.cnt == 3'(CWG_WAKE_CYCLES - 1)) begin
                    // only warm-reset debug cores stay dark, others start
                    nxt_st.stuck        = st_ff.dbg_at_reset;              // [RULE_02] [RULE_07]
                    nxt_st.run          = ~st_ff.dbg_at_reset;             // [RULE_04] [RULE_06]
                    nxt_st.dbg_at_reset = '0;
                    nxt_st.state        = CWG_ST_RUN;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 3'h1;
                end
            end
            default: begin
                nxt_st.state = CWG_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff       <= '0;
            st_ff.s1    <= 3'h7;
            st_ff.s2    <= 3'h7;
            st_ff.prev  <= 3'h7;
            st_ff.state <= CWG_ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign core_run_o   = st_ff.run;
    assign core_stuck_o = st_ff.stuck;
    assign core_dbg_o   = dbg_bus.dbg_state;
    assign emu_dbg_o    = st_ff.emu;
endmodule

//--- cwg_monitor.sv
// checker watching the core wakeup gate ports
module cwg_monitor #(parameter int unsigned N = 4) (
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic         por_n_i,
    input wire logic         full_chip_reset_pin_n_i,
    input wire logic         warm_reset_pin_n_i,
    input wire logic [N-1:0] dbg_halt_i,
    input wire logic [N-1:0] dbg_free_run_i,
    input wire logic [N-1:0] dbg_detach_i,
    input wire logic [N-1:0] core_run_o,
    input wire logic [N-1:0] core_stuck_o,
    input wire logic [N-1:0] core_dbg_o,
    input wire logic         emu_dbg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_or; emu_dbg_o == |$past(core_dbg_o); endproperty
    a_or: assert property (p_or) else $error("emu flag");
    property p_excl; (core_run_o & core_stuck_o) == '0; endproperty
    a_excl: assert property (p_excl) else $error("run and stuck");
    property p_warm; $fell(warm_reset_pin_n_i) |-> ##[1:4] core_run_o == '0; endproperty
    a_warm: assert property (p_warm) else $error("warm stop");
    property p_hard; !(por_n_i && full_chip_reset_pin_n_i) |-> ##[1:4] core_run_o == '0;
    endproperty
    a_hard: assert property (p_hard) else $error("hard stop");
    property p_clean; $rose(warm_reset_pin_n_i) && core_dbg_o == '0 |-> ##[4:12] &core_run_o;
    endproperty
    a_clean: assert property (p_clean) else $error("clean wake");
    // hard reset also clears, so a drop just after one is allowed
    property p_clr; $fell(core_dbg_o[0]) |-> $past(dbg_free_run_i[0] & dbg_detach_i[0], 3)
        || !$past(por_n_i && full_chip_reset_pin_n_i, 3); endproperty
    a_clr: assert property (p_clr) else $error("debug clear");
    property p_stk; $rose(core_stuck_o[0]) |-> core_dbg_o[0]; endproperty
    a_stk: assert property (p_stk) else $error("stuck cause");
    property p_set; $rose(dbg_halt_i[0]) |-> ##[2:4] core_dbg_o[0]; endproperty
    a_set: assert property (p_set) else $error("debug set");
endmodule
bind cwg_top cwg_monitor #(.N(N)) u_mon (.*);

//--- cwg_dbg_model.sv
// debug emulator model driving per-core session requests
module cwg_dbg_model #(parameter int unsigned N = 4) (
    input  wire logic    clk_i,
    output logic [N-1:0] halt_o,
    output logic [N-1:0] attach_o,
    output logic [N-1:0] free_run_o,
    output logic [N-1:0] detach_o
);
    initial begin
        {halt_o, attach_o, free_run_o, detach_o} = '0;
    end
    task open(input logic [N-1:0] m);
        @(negedge clk_i);
        halt_o = m;
        attach_o = m;
        repeat (4) @(negedge clk_i);
        halt_o = '0;
        attach_o = '0;
    endtask
    // free-run first, detach after, both held so the clear is seen
    task close(input logic [1:0] how);
        @(negedge clk_i);
        if (how[0]) free_run_o = '1;
        repeat (4) @(negedge clk_i);
        if (how[1]) detach_o = '1;
        repeat (8) @(negedge clk_i);
        free_run_o = '0;
        detach_o = '0;
        repeat (4) @(negedge clk_i);
    endtask
endmodule

//--- cwg_top_tb_top.sv
// self-checking bench for the core wakeup gate
module cwg_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i, rst_i, por_n_i;
    logic       full_chip_reset_pin_n_i, warm_reset_pin_n_i;
    logic [3:0] dbg_halt_i, dbg_attach_i, dbg_free_run_i, dbg_detach_i;
    logic [3:0] core_run_o, core_stuck_o, core_dbg_o;
    logic       emu_dbg_o;
    int         error_cnt, n_compared;
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {por_n_i, full_chip_reset_pin_n_i, warm_reset_pin_n_i} = 3'h7;
        error_cnt = 0;
        n_compared = 0;
    end
    always #2.5 clk_i = ~clk_i;
    cwg_top #(.N(4)) DUT (.*);
    cwg_dbg_model #(.N(4)) emu (.clk_i(clk_i), .halt_o(dbg_halt_i), .attach_o(dbg_attach_i),
        .free_run_o(dbg_free_run_i), .detach_o(dbg_detach_i));
    task print_verdict;
        if (error_cnt == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string nm, input logic [3:0] s, input logic [3:0] e);
        n_compared++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s exp %h seen %h", nm, e, s);
        end
    endtask
    // k: 0 power-on, 1 full-chip, 2 warm; waits bounded for the wake
    task pulse(input int k);
        @(negedge clk_i);
        por_n_i = (k != 0);
        full_chip_reset_pin_n_i = (k != 1);
        warm_reset_pin_n_i = (k != 2);
        repeat (5) @(negedge clk_i);
        {por_n_i, full_chip_reset_pin_n_i, warm_reset_pin_n_i} = 3'h7;
        for (int i = 0; i < 40 && core_run_o === 4'h0; i++) @(negedge clk_i);
        if (core_run_o === 4'h0) begin
            error_cnt++;
            print_verdict();
        end
        repeat (2) @(negedge clk_i);
    endtask
    initial begin
        repeat (20) @(negedge clk_i);
        rst_i = 0;
        repeat (12) @(negedge clk_i);
        chk("run", core_run_o, 4'hF);
        pulse(2);
        chk("run", core_run_o, 4'hF);
        emu.open(4'h5);
        repeat (3) @(negedge clk_i);
        chk("dbg", core_dbg_o, 4'h5);
        chk("emu", {3'h0, emu_dbg_o}, 4'h1);
        pulse(2);
        chk("run", core_run_o, 4'hA);
        chk("stuck", core_stuck_o, 4'h5);
        pulse(1);
        chk("stuck", core_stuck_o, 4'h0);
        emu.open(4'hF);
        pulse(0);
        chk("run", core_run_o, 4'hF);
        // one step skipped each pass: free-run only, then detach only
        for (int m = 1; m < 3; m++) begin
            emu.open(4'h3);
            emu.close(m[1:0]);
            chk("dbg", core_dbg_o, 4'h3);
            pulse(2);
            chk("stuck", core_stuck_o, 4'h3);
            pulse(1);
        end
        emu.open(4'hF);
        emu.close(2'h3);
        chk("dbg", core_dbg_o, 4'h0);
        pulse(2);
        chk("run", core_run_o, 4'hF);
        print_verdict();
    end
endmodule
